//--- design/xtal_startup_pkg.sv
package xtal_startup_pkg;

	// ---------------------------------------------------------------
	// fuse codes, raw as read (1 = unprogrammed, 0 = programmed)
	// ---------------------------------------------------------------
	localparam logic [2:0] SRC_LP_BAND0  = 3'h4;   // 0.4-0.9 MHz, resonator only
	localparam logic [2:0] SRC_LP_BAND1  = 3'h5;   // 0.9-3.0 MHz
	localparam logic [2:0] SRC_LP_BAND2  = 3'h6;   // 3.0-8.0 MHz
	localparam logic [2:0] SRC_LP_BAND3  = 3'h7;   // 8.0-16.0 MHz
	localparam logic [2:0] SRC_FULLSWING = 3'h3;   // 0.4-20 MHz
	localparam logic       FUSE_PROGRAMMED = 1'h0;

	// ---------------------------------------------------------------
	// field positions inside the source-select fuse word
	// ---------------------------------------------------------------
	localparam int SRC_MODE_LSB = 1;
	localparam int SRC_IDX_BIT  = 0;

	// ---------------------------------------------------------------
	// counts
	// ---------------------------------------------------------------
	localparam int CNT_W = 15;
	localparam logic [CNT_W-1:0] WAKE_CYC_SHORT = 15'h0102;  // 258 oscillator cycles
	localparam logic [CNT_W-1:0] WAKE_CYC_MID   = 15'h0400;  // 1K
	localparam logic [CNT_W-1:0] WAKE_CYC_LONG  = 15'h4000;  // 16K
	localparam logic [CNT_W-1:0] WDT_CYC_NONE   = 15'h0000;  // no time-out
	localparam logic [CNT_W-1:0] WDT_CYC_SHORT  = 15'h0200;  // 512, about 4.1 ms
	localparam logic [CNT_W-1:0] WDT_CYC_LONG   = 15'h2000;  // 8K, about 65 ms
	localparam logic [CNT_W-1:0] FIXED_RST_CYC  = 15'h000e;  // 14 oscillator cycles
	localparam logic [2:0]       DIV8_LAST      = 3'h7;
	localparam logic [2:0]       DIV_RESET      = 3'h0;

	typedef enum logic [2:0] {
		ST_HOLD,
		ST_TIMEOUT,
		ST_FIXED,
		ST_RUN,
		ST_WAKE
	} startup_state_e;

endpackage

//--- design/startup_cnt_if.sv
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// link between sequencer and synchronous start-up counter
// ---------------------------------------------------------------
interface startup_cnt_if;
	logic                              load;
	logic                              tick;
	logic [xtal_startup_pkg::CNT_W-1:0] target;
	logic                              done;

	modport ctrl (output load, output tick, output target, input done);
	modport cnt  (input load, input tick, input target, output done);
endinterface

`default_nettype wire

//--- design/startup_counter.sv
`timescale 1ns/1ps
`default_nettype none

module startup_counter (
	// clock and reset
	input  wire logic sysClk,
	input  wire logic rstN,
	// control
	startup_cnt_if.cnt cnt
);
	import xtal_startup_pkg::*;

	logic [CNT_W-1:0] count_r;
	logic [CNT_W-1:0] count_nxt;

	// done is a compare so a zero target finishes at once
	assign cnt.done = (count_r == cnt.target);

	// ---------------------------------------------------------------
	// counting
	// ---------------------------------------------------------------
	// load wins over tick, and the counter parks on the target
	always_comb begin
		count_nxt = count_r;
		if (cnt.load) begin
			count_nxt = '0;
		end else if (cnt.tick && !cnt.done) begin
			count_nxt = CNT_W'(count_r + 1'b1);
		end
	end

	always_ff @(posedge sysClk or negedge rstN) begin
		if (!rstN) begin
			count_r <= '0;
		end else begin
			count_r <= count_nxt;
		end
	end

endmodule

`default_nettype wire

//--- design/crystal_startup_delay_select.sv
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Upper source-select bits 100..111 pick the low power crystal oscillator in four frequency bands.
// - Upper source-select bits 011 pick the full swing crystal oscillator for 0.4 to 20 MHz.
// - The start-up index is the lowest source-select bit followed by the two start-up fuse bits.
// - Index 000 and 001 wake after 258 cycles; reset delay is 14 cycles plus 4.1 ms or 65 ms.
// - Index 010, 011 and 100 wake after 1K cycles; reset delay is 14, 14 plus 4.1 ms, 14 plus 65 ms.
// - Index 101, 110 and 111 wake after 16K cycles; reset delay is 14, 14 plus 4.1 ms, 14 plus 65 ms.
// - The full swing oscillator uses the same index-to-delay mapping as the low power one.
// - A programmed divide-by-eight fuse divides the oscillator by eight for the system clock.
// - Waking from power-save or power-down applies only the start-up count, no time-out.
// - The reset time-out counts 0, 512 or 8K watchdog oscillator cycles as the fuses select.
// - Internal reset stays active while the time-out and fixed counts run and is released when they complete; wake counts leave it inactive.
// - A fuse bit read as one is unprogrammed and a fuse bit read as zero is programmed.

module crystal_startup_delay_select #(
	parameter logic [xtal_startup_pkg::CNT_W-1:0] WakeCycLong = xtal_startup_pkg::WAKE_CYC_LONG,
	parameter logic [xtal_startup_pkg::CNT_W-1:0] WdtCycLong  = xtal_startup_pkg::WDT_CYC_LONG
) (
	// clock and reset
	input  wire logic       sysClk,
	input  wire logic       arst_n,
	// fuses, raw as read
	input  wire logic [3:0] clockSourceSelectFuses,
	input  wire logic [1:0] startupTimeFuses,
	input  wire logic       divideByEightFuse,
	// events from the rest of the chip
	input  wire logic       resetSourceActive,
	input  wire logic       wdtTick,
	input  wire logic       wakeStart,
	// oscillator selection
	output logic            lowPowerSel,
	output logic            fullSwingSel,
	output logic [1:0]      freqBand,
	// start-up status
	output logic            internalReset,
	output logic            clockReady,
	output logic [2:0]      startupIndex,
	// system clock enable
	output logic            sysClkEnable
);
	import xtal_startup_pkg::*;

	// ---------------------------------------------------------------
	// reset release through two flops
	// ---------------------------------------------------------------
	logic rstMeta_r;
	logic rstN_r;

	always_ff @(posedge sysClk or negedge arst_n) begin
		if (!arst_n) begin
			rstMeta_r <= 1'b0;
			rstN_r    <= 1'b0;
		end else begin
			rstMeta_r <= 1'b1;
			rstN_r    <= rstMeta_r;
		end
	end

	// ---------------------------------------------------------------
	// fuse decode
	// ---------------------------------------------------------------
	logic [2:0]       srcMode;
	logic [2:0]       idx;
	logic [CNT_W-1:0] wakeCyc;
	logic [CNT_W-1:0] wdtCyc;
	logic             lpSel_nxt;
	logic             fsSel_nxt;
	logic [1:0]       band_nxt;

	assign srcMode = clockSourceSelectFuses[SRC_MODE_LSB +: 3];
	assign idx     = {clockSourceSelectFuses[SRC_IDX_BIT], startupTimeFuses};

	// codes are compared raw, so a bit read as one is unprogrammed
	always_comb begin
		lpSel_nxt = 1'b0;
		fsSel_nxt = 1'b0;
		band_nxt  = 2'h0;
		unique case (srcMode)
			SRC_LP_BAND0,
			SRC_LP_BAND1,
			SRC_LP_BAND2,
			SRC_LP_BAND3: begin
				lpSel_nxt = 1'b1;
				band_nxt  = srcMode[1:0];
			end
			SRC_FULLSWING: begin
				fsSel_nxt = 1'b1;
			end
			default: begin
				lpSel_nxt = 1'b0;
			end
		endcase
	end

	// one table serves both oscillators
	always_comb begin
		unique case (idx)
			3'h0: begin wakeCyc = WAKE_CYC_SHORT; wdtCyc = WDT_CYC_SHORT; end
			3'h1: begin wakeCyc = WAKE_CYC_SHORT; wdtCyc = WdtCycLong;    end
			3'h2: begin wakeCyc = WAKE_CYC_MID;   wdtCyc = WDT_CYC_NONE;  end
			3'h3: begin wakeCyc = WAKE_CYC_MID;   wdtCyc = WDT_CYC_SHORT; end
			3'h4: begin wakeCyc = WAKE_CYC_MID;   wdtCyc = WdtCycLong;    end
			3'h5: begin wakeCyc = WakeCycLong;    wdtCyc = WDT_CYC_NONE;  end
			3'h6: begin wakeCyc = WakeCycLong;    wdtCyc = WDT_CYC_SHORT; end
			3'h7: begin wakeCyc = WakeCycLong;    wdtCyc = WdtCycLong;    end
		endcase
	end

	// ---------------------------------------------------------------
	// start-up sequencer
	// ---------------------------------------------------------------
	startup_cnt_if cntBus ();

	startup_counter uCounter (
		.sysClk (sysClk),
		.rstN   (rstN_r),
		.cnt    (cntBus.cnt)
	);

	startup_state_e   state_r;
	startup_state_e   state_nxt;
	logic [CNT_W-1:0] target_r;
	logic [CNT_W-1:0] target_nxt;
	logic             load;
	logic             tick;

	assign cntBus.load   = load;
	assign cntBus.tick   = tick;
	assign cntBus.target = target_r;

	// the fuse table is sampled at load time, so changing fuses mid-count has no effect
	always_comb begin
		state_nxt  = state_r;
		target_nxt = target_r;
		load       = 1'b0;
		tick       = 1'b0;
		unique case (state_r)
			ST_HOLD: begin
				if (!resetSourceActive) begin
					load       = 1'b1;
					target_nxt = wdtCyc;
					state_nxt  = ST_TIMEOUT;
				end
			end
			ST_TIMEOUT: begin
				tick = wdtTick;
				if (cntBus.done) begin
					load       = 1'b1;
					target_nxt = FIXED_RST_CYC;
					state_nxt  = ST_FIXED;
				end
			end
			ST_FIXED: begin
				tick = 1'b1;
				if (cntBus.done) begin
					state_nxt = ST_RUN;
				end
			end
			ST_RUN: begin
				if (wakeStart) begin
					load       = 1'b1;
					target_nxt = wakeCyc;
					state_nxt  = ST_WAKE;
				end
			end
			ST_WAKE: begin
				tick = 1'b1;
				if (cntBus.done) begin
					state_nxt = ST_RUN;
				end
			end
		endcase
		// any other reset source restarts the whole sequence
		if (resetSourceActive) begin
			load      = 1'b0;
			state_nxt = ST_HOLD;
		end
	end

	always_ff @(posedge sysClk or negedge rstN_r) begin
		if (!rstN_r) begin
			state_r  <= ST_HOLD;
			target_r <= '0;
		end else begin
			state_r  <= state_nxt;
			target_r <= target_nxt;
		end
	end

	// ---------------------------------------------------------------
	// system clock prescaler
	// ---------------------------------------------------------------
	logic [2:0] div_r;
	logic [2:0] div_nxt;
	logic       div8On;

	assign div8On = (divideByEightFuse == FUSE_PROGRAMMED);

	// counts only when dividing and is held at zero otherwise; the enable is one pulse in eight when dividing
	always_comb begin
		div_nxt = div8On ? 3'(div_r + 1'b1) : DIV_RESET;
	end

	always_ff @(posedge sysClk or negedge rstN_r) begin
		if (!rstN_r) begin
			div_r <= DIV_RESET;
		end else begin
			div_r <= div_nxt;
		end
	end

	// ---------------------------------------------------------------
	// registered outputs
	// ---------------------------------------------------------------
	logic intRst_nxt;
	logic ready_nxt;
	logic clkEn_nxt;

	always_comb begin
		intRst_nxt = (state_nxt == ST_HOLD) || (state_nxt == ST_TIMEOUT) || (state_nxt == ST_FIXED);
		ready_nxt  = (state_nxt == ST_RUN);
		clkEn_nxt  = div8On ? (div_nxt == DIV8_LAST) : 1'b1;
	end

	always_ff @(posedge sysClk or negedge rstN_r) begin
		if (!rstN_r) begin
			lowPowerSel   <= 1'b0;
			fullSwingSel  <= 1'b0;
			freqBand      <= 2'h0;
			internalReset <= 1'b1;
			clockReady    <= 1'b0;
			startupIndex  <= 3'h0;
			sysClkEnable  <= 1'b0;
		end else begin
			lowPowerSel   <= lpSel_nxt;
			fullSwingSel  <= fsSel_nxt;
			freqBand      <= band_nxt;
			internalReset <= intRst_nxt;
			clockReady    <= ready_nxt;
			startupIndex  <= idx;
			sysClkEnable  <= clkEn_nxt;
		end
	end

endmodule

`default_nettype wire

//--- dv/xtal_startup_assertions.sv
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// port checker
// ---------------------------------------------------------------
module xtal_startup_chk (
	// clock and reset
	input wire logic       sysClk,
	input wire logic       arst_n,
	// fuses and events
	input wire logic [3:0] clockSourceSelectFuses,
	input wire logic [1:0] startupTimeFuses,
	input wire logic       divideByEightFuse,
	input wire logic       resetSourceActive,
	input wire logic       wakeStart,
	// outputs
	input wire logic       lowPowerSel,
	input wire logic       fullSwingSel,
	input wire logic [1:0] freqBand,
	input wire logic       internalReset,
	input wire logic       clockReady,
	input wire logic [2:0] startupIndex,
	input wire logic       sysClkEnable
);
	default clocking @(posedge sysClk); endclocking
	default disable iff (!arst_n);
	logic [2:0] upCnt_r, upCnt_nxt;
	logic       rdy;
	// settle time: reset synchroniser plus one decode edge
	always_comb upCnt_nxt = (upCnt_r == 3'h5) ? upCnt_r : upCnt_r + 3'h1;
	always_ff @(posedge sysClk or negedge arst_n) begin
		if (!arst_n) upCnt_r <= 3'h0;
		else upCnt_r <= upCnt_nxt;
	end
	assign rdy = (upCnt_r == 3'h5);
	// multi-step timings
	sequence s_wakeLow; ##259 !clockReady ##1 clockReady; endsequence
	sequence s_fixed; ##16 internalReset ##1 !internalReset; endsequence
	sequence s_div; !sysClkEnable[*7] ##1 sysClkEnable; endsequence
	property p_lpSel; rdy |-> lowPowerSel == $past(clockSourceSelectFuses[3]); endproperty
	a_lpSel: assert property (p_lpSel) else $error("low power select wrong");
	property p_band;
		rdy |-> freqBand == ($past(clockSourceSelectFuses[3]) ? $past(clockSourceSelectFuses[2:1]) : 2'h0);
	endproperty
	a_band: assert property (p_band) else $error("band wrong");
	property p_fsSel; rdy |-> fullSwingSel == ($past(clockSourceSelectFuses[3:1]) == 3'h3); endproperty
	a_fsSel: assert property (p_fsSel) else $error("full swing select wrong");
	property p_idx; rdy |-> startupIndex == {$past(clockSourceSelectFuses[0]), $past(startupTimeFuses)}; endproperty
	a_idx: assert property (p_idx) else $error("index wrong");
	property p_wake258;
		rdy && clockReady && wakeStart && !resetSourceActive && startupIndex[2:1] == 2'h0 |-> s_wakeLow;
	endproperty
	a_wake258: assert property (p_wake258) else $error("short wake length wrong");
	property p_wakeNoRst; rdy && clockReady && wakeStart && !resetSourceActive |=> !internalReset[*8]; endproperty
	a_wakeNoRst: assert property (p_wakeNoRst) else $error("reset during wake");
	property p_release; rdy && $fell(internalReset) |-> clockReady; endproperty
	a_release: assert property (p_release) else $error("release without ready");
	property p_fixed; rdy && internalReset && $fell(resetSourceActive) && startupIndex == 3'h2 |-> s_fixed; endproperty
	a_fixed: assert property (p_fixed) else $error("fixed delay wrong");
	property p_div; rdy && !divideByEightFuse && !$past(divideByEightFuse) && sysClkEnable |=> s_div; endproperty
	a_div: assert property (p_div) else $error("divide spacing wrong");
	property p_noDiv; rdy && divideByEightFuse && $past(divideByEightFuse) |-> sysClkEnable; endproperty
	a_noDiv: assert property (p_noDiv) else $error("undivided enable low");
endmodule

bind crystal_startup_delay_select xtal_startup_chk u_chk (.sysClk, .arst_n, .clockSourceSelectFuses,
	.startupTimeFuses, .divideByEightFuse, .resetSourceActive, .wakeStart, .lowPowerSel, .fullSwingSel,
	.freqBand, .internalReset, .clockReady, .startupIndex, .sysClkEnable);

`default_nettype wire

//--- dv/crystal_startup_delay_select_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
	$display("unexpected %s exp %0h got %0h", nm, e, g); end end

module crystal_startup_delay_select_tb;
	import xtal_startup_pkg::*;
	// shortened long counts keep the run brief
	localparam logic [CNT_W-1:0] WakeL = 15'h0028;
	localparam logic [CNT_W-1:0] WdtL  = 15'h0014;
	logic       sysClk, arst_n, divF, rsa, wake, lp, fs, iRst, cRdy, en;
	logic       tick = 1'b0;
	logic [3:0] src;
	logic [1:0] startup_time_fuses, band;
	logic [2:0] idx;
	int         err_total, compares, n, i;
	int         wdt[8] = '{512, WdtL, 0, 512, WdtL, 0, 512, WdtL};
	int         wk[8]  = '{258, 258, 1024, 1024, 1024, WakeL, WakeL, WakeL};

	crystal_startup_delay_select #(.WakeCycLong(WakeL), .WdtCycLong(WdtL)) u_dut (
		.sysClk(sysClk), .arst_n(arst_n), .clockSourceSelectFuses(src), .startupTimeFuses(startup_time_fuses),
		.divideByEightFuse(divF), .resetSourceActive(rsa), .wdtTick(tick), .wakeStart(wake),
		.lowPowerSel(lp), .fullSwingSel(fs), .freqBand(band), .internalReset(iRst),
		.clockReady(cRdy), .startupIndex(idx), .sysClkEnable(en));

	// ---------------------------------------------------------------
	// clock, watchdog ticks, helpers
	// ---------------------------------------------------------------
	initial begin
		sysClk = 1'b0;
		forever #12.5 sysClk = ~sysClk;
	end
	// tick every other cycle, so time-out length doubles
	always @(posedge sysClk) tick <= #1 ~tick;

	task step;
		@(posedge sysClk);
		#1;
	endtask

	task tally_and_finish;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// hold, release, time-out plus fixed part, then one wake
	task boot(input int k);
		src = {(k[0] ? 3'h3 : 3'h5), k[2]};  // resonator-only band never used here
		startup_time_fuses = k[1:0];                        // short wakes with low power band 1 and full swing
		rsa = 1'b1;
		repeat (3) step;
		`CHK("holdRst", 1'b1, iRst)
		`CHK("holdRdy", 1'b0, cRdy)
		rsa = 1'b0;
		n = 0;
		while (iRst === 1'b1 && n < 20000) begin step; n++; end
		`CHK("rstLen", 1'b1, n >= 2*wdt[k]+14 && n <= 2*wdt[k]+18)
		`CHK("runRdy", 1'b1, cRdy)
		wake = 1'b1;
		step;
		wake = 1'b0;
		n = 0;
		while (cRdy === 1'b0 && n < 20000) begin step; n++; end
		`CHK("wakeLen", wk[k]+1, n)
		$display("boot index %0d done", k);
	endtask

	// ---------------------------------------------------------------
	// tests
	// ---------------------------------------------------------------
	initial begin
		arst_n = 1'b0; src = 4'hf; startup_time_fuses = 2'h0; divF = 1'b1; rsa = 1'b1; wake = 1'b0;
		err_total = 0;
		compares = 0;
		repeat (10) @(posedge sysClk);
		#1 arst_n = 1'b1;
		// internal release takes two edges; decode checks start after it
		repeat (2) step;
		for (i = 0; i < 16; i++) begin
			src = i[3:0];
			startup_time_fuses = i[1:0];
			step;
			step;
			`CHK("lowPower", i[3], lp)
			`CHK("fullSwing", i[3:1] == 3'h3, fs)
			`CHK("band", i[3] ? i[2:1] : 2'h0, band)
			`CHK("index", {i[0], i[1:0]}, idx)
		end
		$display("decode test done");
		for (i = 0; i < 8; i++) boot(i);
		n = 0;
		repeat (16) begin step; n += en; end
		`CHK("undivided", 16, n)
		divF = 1'b0;
		repeat (2) step;
		n = 0;
		repeat (16) begin step; n += en; end
		`CHK("divided", 2, n)
		$display("divider test done");
		tally_and_finish;
	end

	// hang guard, well beyond the expected length
	initial begin
		repeat (40000) @(posedge sysClk);
		err_total++;
		$display("watchdog expired");
		tally_and_finish;
	end
endmodule

`default_nettype wire
